// ---- rcm_ctrl.sv ----
`include "rcm_regs.svh"
module rcm_ctrl
  import rcm_pkg::*;
#(
  parameter int MEAS_UNIT_CYC  = (`RCM_DLY_MEAS_NS + `RCM_CLK_PERIOD_NS - 1) / `RCM_CLK_PERIOD_NS,
  parameter int CAL_UNIT_CYC   = (`RCM_DLY_CAL_NS + `RCM_CLK_PERIOD_NS - 1) / `RCM_CLK_PERIOD_NS,
  parameter int SLOPE_UNIT_CYC = (`RCM_DLY_SLOPE_NS + `RCM_CLK_PERIOD_NS - 1) / `RCM_CLK_PERIOD_NS,
  parameter int CONV_SAMPLES   = `RCM_CONV_SAMPLES
)(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // register port
  input  wire logic [4:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // chip state and mode pin
  input  wire logic        CHIP_DISABLE,
  input  wire logic        MODE_SELECT_PIN_B,
  output logic             TRX_STATE_ENABLE,
  // receive events and indicators
  input  wire logic        RX_PACKET_DONE,
  input  wire logic        RX_SYNC,
  input  wire logic        PKT_IND,
  input  wire logic        RDY_IND,
  output logic             PKT_RDY_PIN,
  // analog front end
  input  wire logic [7:0]  TEMP_SAMPLE,
  input  wire logic [7:0]  STRENGTH_SAMPLE,
  input  wire logic [6:0]  IF_CAL_RESULT,
  output logic             ADC_CLK_EN,
  output logic             SAMPLE_STROBE,
  output logic [6:0]       CAL_SELECT,
  output logic [6:0]       IF_FILTER_VALUE
);

  localparam int DW = 20;

  function automatic logic [DW-1:0] delay_cycles(input int unit, input logic [2:0] fld);
    logic [DW-1:0] base;
    base = DW'(unit);
    return base << fld;
  endfunction

  function automatic logic is_write(input logic [4:0] a, input logic [4:0] ofs);
    return WR && (a == ofs);
  endfunction

  rcm_state_t     state_reg;
  rcm_job_t       job_reg;
  rcm_job_t       job_next;
  logic           start_job;
  logic [DW-1:0]  dly_cnt_reg;
  logic [7:0]     conv_cnt_reg;
  logic [3:0]     adc_div_reg;
  logic           adc_tick;
  logic           sample_tick;

  logic           temp_go_reg;
  logic [1:0]     trig_sel_reg;
  logic           manual_reg;
  logic [4:0]     cmd_reg;
  logic [4:0]     served_reg;
  logic [4:0]     cal_pend;
  logic           trx_en_reg;
  logic           cal_en_reg;
  logic           str_go_reg;
  logic           pin_sel_reg;
  logic           pin_inv_reg;
  logic           test_b_reg;
  logic           rsvd0_reg;
  logic [12:0]    adc_cfg_reg;
  logic [7:0]     temp_code_reg;
  logic [7:0]     str_code_reg;
  logic [6:0]     if_value_reg;
  logic           str_trig_reg;
  logic           str_event;
  logic [15:0]    rd_next;
  logic           finish_now;

  logic wr_a;
  logic wr_b;
  assign wr_a = is_write(ADDR, `RCM_OFS_CAL_A);
  assign wr_b = is_write(ADDR, `RCM_OFS_CAL_B);
  assign finish_now = (state_reg == ST_FINISH) && !CHIP_DISABLE;

  // calibrations waiting to run under the current enable
  assign cal_pend = cmd_reg & ~served_reg & {5{cal_en_reg}};

  // strength trigger: packet landed, sync, or the go bit alone
  always_comb
  begin
    case (trig_sel_reg)
      2'b00:   str_event = RX_PACKET_DONE;
      2'b01:   str_event = RX_SYNC;
      default: str_event = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      str_trig_reg <= 1'b0;
    else if (CHIP_DISABLE || !str_go_reg || (finish_now && job_reg == JOB_STR))
      str_trig_reg <= 1'b0;
    else if (str_event)
      str_trig_reg <= 1'b1;
  end

  // fixed order: IF, data filter, demod, high slope, low slope, then measurements
  always_comb
  begin
    start_job = 1'b1;
    job_next  = JOB_IFC;
    if (cal_pend[0])
      job_next = JOB_IFC;
    else if (cal_pend[1])
      job_next = JOB_DFC;
    else if (cal_pend[2])
      job_next = JOB_DEMOD_CAL_CMD;
    else if (cal_pend[3])
      job_next = JOB_RHC;
    else if (cal_pend[4])
      job_next = JOB_RLC;
    else if (temp_go_reg)
      job_next = JOB_TEMP;
    else if (str_go_reg && str_trig_reg)
      job_next = JOB_STR;
    else
      start_job = 1'b0;
  end

  // ADC sample clock divider, IF rate over 2^(n+1)
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      adc_div_reg <= 4'h0;
    else if (state_reg != ST_SAMPLE || adc_tick)
      adc_div_reg <= 4'h0;
    else
      adc_div_reg <= adc_div_reg + 4'h1;
  end
  assign adc_tick = (adc_div_reg == 4'((5'h02 << adc_cfg_reg[1:0]) - 5'h01));
  assign sample_tick = (job_reg == JOB_DEMOD_CAL_CMD) ? adc_tick : 1'b1;

  // sequencer
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg    <= ST_IDLE;
      job_reg      <= JOB_IFC;
      dly_cnt_reg  <= '0;
      conv_cnt_reg <= 8'h00;
    end
    else if (CHIP_DISABLE)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (start_job)
          begin
            job_reg   <= job_next;
            state_reg <= ST_DELAY;
            case (job_next)
              JOB_TEMP, JOB_STR:
                dly_cnt_reg <= delay_cycles(MEAS_UNIT_CYC, adc_cfg_reg[6:4]) - 1'b1;
              JOB_RHC, JOB_RLC:
                dly_cnt_reg <= delay_cycles(SLOPE_UNIT_CYC, adc_cfg_reg[12:10]) - 1'b1;
              default:
                dly_cnt_reg <= delay_cycles(CAL_UNIT_CYC, adc_cfg_reg[9:7]) - 1'b1;
            endcase
          end
        ST_DELAY:
          if (dly_cnt_reg == '0)
          begin
            state_reg    <= ST_SAMPLE;
            conv_cnt_reg <= 8'h00;
          end
          else
            dly_cnt_reg <= dly_cnt_reg - 1'b1;
        ST_SAMPLE:
          if (sample_tick)
          begin
            if (conv_cnt_reg == 8'(CONV_SAMPLES - 1))
              state_reg <= ST_FINISH;
            conv_cnt_reg <= conv_cnt_reg + 8'h01;
          end
        ST_FINISH:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // strobes toward the analog side
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SAMPLE_STROBE <= 1'b0;
      ADC_CLK_EN    <= 1'b0;
      CAL_SELECT    <= 7'h00;
    end
    else
    begin
      SAMPLE_STROBE <= (state_reg == ST_SAMPLE) && sample_tick && !CHIP_DISABLE;
      ADC_CLK_EN    <= (state_reg == ST_SAMPLE) && (job_reg == JOB_DEMOD_CAL_CMD) && adc_tick;
      CAL_SELECT    <= (state_reg == ST_IDLE || CHIP_DISABLE) ? 7'h00 : (7'h01 << job_reg);
    end
  end

  // captured codes
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      temp_code_reg <= 8'h00;
      str_code_reg  <= 8'h00;
    end
    else if (finish_now)
    begin
      if (job_reg == JOB_TEMP)
        temp_code_reg <= TEMP_SAMPLE;
      if (job_reg == JOB_STR)
        str_code_reg <= STRENGTH_SAMPLE;
    end
  end

  // IF filter value: calibration result or software value
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      if_value_reg <= `RCM_RST_IF_VALUE;
    else if (manual_reg && is_write(ADDR, `RCM_OFS_IF_TRIM))
      if_value_reg <= WDATA[7:1];
    else if (!manual_reg && finish_now && job_reg == JOB_IFC)
      if_value_reg <= IF_CAL_RESULT;
  end
  assign IF_FILTER_VALUE = if_value_reg;

  // control register A
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      trig_sel_reg <= 2'b00;
      manual_reg   <= 1'b0;
      cmd_reg      <= 5'h00;
    end
    else if (wr_a)
    begin
      trig_sel_reg <= WDATA[`RCM_A_TRIG_LSB +: 2];
      manual_reg   <= WDATA[`RCM_A_MANUAL];
      cmd_reg      <= WDATA[`RCM_A_CMD_LSB +: 5];
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      temp_go_reg <= 1'b0;
    else if (CHIP_DISABLE)
      temp_go_reg <= 1'b0;
    else if (wr_a && WDATA[`RCM_A_TEMP_GO])
      temp_go_reg <= 1'b1;
    else if (wr_a)
      temp_go_reg <= 1'b0;
    else if (finish_now && job_reg == JOB_TEMP)
      temp_go_reg <= 1'b0;
  end

  // calibrations already finished under the current enable
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      served_reg <= 5'h00;
    else if (CHIP_DISABLE || !cal_en_reg)
      served_reg <= 5'h00;
    else if (finish_now && job_reg <= JOB_RLC)
      served_reg <= served_reg | (5'h01 << job_reg);
  end

  // control register B
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pin_sel_reg <= 1'b0;
      pin_inv_reg <= 1'b0;
      test_b_reg  <= 1'b0;
      rsvd0_reg   <= 1'b0;
    end
    else if (wr_b)
    begin
      pin_sel_reg <= WDATA[`RCM_B_PIN_SEL];
      pin_inv_reg <= WDATA[`RCM_B_PIN_INV];
      test_b_reg  <= WDATA[`RCM_B_TEST_B];
      rsvd0_reg   <= WDATA[`RCM_B_RSVD0];
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      trx_en_reg <= `RCM_RST_TRX_EN;
    else if (CHIP_DISABLE)
      trx_en_reg <= `RCM_RST_TRX_EN;
    else if (wr_b)
      trx_en_reg <= WDATA[`RCM_B_TRX_EN];
  end
  assign TRX_STATE_ENABLE = trx_en_reg && MODE_SELECT_PIN_B;

  // self-clearing enables; a write in the clearing cycle wins
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      cal_en_reg <= 1'b0;
    else if (CHIP_DISABLE)
      cal_en_reg <= 1'b0;
    else if (wr_b)
      cal_en_reg <= WDATA[`RCM_B_CAL_EN];
    else if (cal_en_reg && cal_pend == 5'h00 && state_reg == ST_IDLE)
      cal_en_reg <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      str_go_reg <= 1'b0;
    else if (CHIP_DISABLE)
      str_go_reg <= 1'b0;
    else if (wr_b)
      str_go_reg <= WDATA[`RCM_B_STR_GO];
    else if (finish_now && job_reg == JOB_STR)
      str_go_reg <= 1'b0;
  end

  // ADC clock setup, write only
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      adc_cfg_reg <= 13'h0000;
    else if (is_write(ADDR, `RCM_OFS_ADC_CLK))
      adc_cfg_reg <= WDATA[12:0];
  end

  // packet/ready pin
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      PKT_RDY_PIN <= 1'b0;
    else
      PKT_RDY_PIN <= (pin_sel_reg ? RDY_IND : PKT_IND) ^ pin_inv_reg;
  end

  // read mux; unmapped offsets and unused bits read zero
  always_comb
  begin
    rd_next = 16'h0000;
    case (ADDR)
      `RCM_OFS_THERMO:   rd_next = {temp_code_reg, 8'h00};
      `RCM_OFS_STRENGTH: rd_next = {str_code_reg, 8'h00};
      `RCM_OFS_CAL_A:
        rd_next = {~temp_go_reg, ~str_go_reg,
                   ~cal_pend[0], ~cal_pend[1], ~cal_pend[2], ~cal_pend[3], ~cal_pend[4],
                   cmd_reg, manual_reg, trig_sel_reg, temp_go_reg};
      `RCM_OFS_CAL_B:
        rd_next = {9'h000, rsvd0_reg, test_b_reg, pin_inv_reg, pin_sel_reg,
                   str_go_reg, cal_en_reg, TRX_STATE_ENABLE};
      `RCM_OFS_IF_TRIM:  rd_next = {if_value_reg, 9'h000};
      default:           rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      RDATA <= 16'h0000;
    else
      RDATA <= RD ? rd_next : 16'h0000;
  end

  property p_temp_clear;
    @(posedge CLK) disable iff (!RESETN)
    (finish_now && job_reg == JOB_TEMP && !wr_a) |=> !temp_go_reg;
  endproperty
  a_temp_clear: assert property (p_temp_clear) else $error("temperature go not cleared");

  property p_temp_rdy;
    @(posedge CLK) disable iff (!RESETN)
    (RD && ADDR == `RCM_OFS_CAL_A && temp_go_reg) |=> !RDATA[`RCM_A_TEMP_RDY];
  endproperty
  a_temp_rdy: assert property (p_temp_rdy) else $error("temperature ready high while busy");

  property p_str_rdy;
    @(posedge CLK) disable iff (!RESETN)
    (RD && ADDR == `RCM_OFS_CAL_A && str_go_reg) |=> !RDATA[`RCM_A_STR_RDY];
  endproperty
  a_str_rdy: assert property (p_str_rdy) else $error("strength ready high while busy");

  property p_cal_gate;
    @(posedge CLK) disable iff (!RESETN)
    (state_reg == ST_IDLE && start_job && job_next <= JOB_RLC) |-> cal_en_reg;
  endproperty
  a_cal_gate: assert property (p_cal_gate) else $error("calibration started without enable");

  property p_cal_en_clear;
    @(posedge CLK) disable iff (!RESETN)
    (cal_en_reg && cal_pend == 5'h00 && state_reg == ST_IDLE && !wr_b) |=> !cal_en_reg;
  endproperty
  a_cal_en_clear: assert property (p_cal_en_clear) else $error("calibration enable stuck");

  property p_adc_spacing;
    @(posedge CLK) disable iff (!RESETN)
    ADC_CLK_EN |=> !ADC_CLK_EN;
  endproperty
  a_adc_spacing: assert property (p_adc_spacing) else $error("ADC clock faster than IF/2");

  property p_trx_mask;
    @(posedge CLK) disable iff (!RESETN)
    (RD && ADDR == `RCM_OFS_CAL_B && !MODE_SELECT_PIN_B) |=> !RDATA[`RCM_B_TRX_EN];
  endproperty
  a_trx_mask: assert property (p_trx_mask) else $error("state enable not masked");

  property p_disable;
    @(posedge CLK) disable iff (!RESETN)
    CHIP_DISABLE |=> (trx_en_reg && !cal_en_reg && !str_go_reg && !temp_go_reg);
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not restore bits");

  property p_unmapped;
    @(posedge CLK) disable iff (!RESETN)
    (RD && (ADDR < `RCM_OFS_THERMO || ADDR > `RCM_OFS_IF_TRIM)) |=> (RDATA == 16'h0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_meas_delay;
    @(posedge CLK) disable iff (!RESETN)
    (state_reg == ST_IDLE && start_job && job_next == JOB_TEMP && !CHIP_DISABLE)
      |=> (dly_cnt_reg == delay_cycles(MEAS_UNIT_CYC, $past(adc_cfg_reg[6:4])) - 1'b1);
  endproperty
  a_meas_delay: assert property (p_meas_delay) else $error("wrong measurement delay");

  property p_pin;
    @(posedge CLK) disable iff (!RESETN)
    (pin_sel_reg && !pin_inv_reg && $stable(pin_sel_reg)) |=> (PKT_RDY_PIN == $past(RDY_IND));
  endproperty
  a_pin: assert property (p_pin) else $error("pin not routed to ready indicator");

endmodule

// ---- rcm_pkg.sv ----
package rcm_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_FINISH} rcm_state_t;
  typedef enum logic [2:0] {
    JOB_IFC, JOB_DFC, JOB_DEMOD_CAL_CMD, JOB_RHC, JOB_RLC, JOB_TEMP, JOB_STR
  } rcm_job_t;
endpackage

// ---- rcm_regs.svh ----
`ifndef RCM_REGS_SVH
`define RCM_REGS_SVH

// register offsets
`define RCM_OFS_THERMO     5'h0A
`define RCM_OFS_STRENGTH   5'h0B
`define RCM_OFS_CAL_A      5'h0C
`define RCM_OFS_CAL_B      5'h0D
`define RCM_OFS_ADC_CLK    5'h0E
`define RCM_OFS_IF_TRIM    5'h0F
// field positions
`define RCM_A_TEMP_GO      0
`define RCM_A_TRIG_LSB     1
`define RCM_A_MANUAL       3
`define RCM_A_CMD_LSB      4
`define RCM_A_TEMP_RDY     15
`define RCM_A_STR_RDY      14
`define RCM_B_TRX_EN       0
`define RCM_B_CAL_EN       1
`define RCM_B_STR_GO       2
`define RCM_B_PIN_SEL      3
`define RCM_B_PIN_INV      4
`define RCM_B_TEST_B       5
`define RCM_B_RSVD0        6
`define RCM_ADC_DIV_LSB    0
`define RCM_ADC_MEAS_LSB   4
`define RCM_ADC_CAL_LSB    7
`define RCM_ADC_SLOPE_LSB  10
// reset values
`define RCM_RST_TRX_EN     1'b1
`define RCM_RST_IF_VALUE   7'h00
// timing
`define RCM_CLK_PERIOD_NS  50
`define RCM_DLY_MEAS_NS    4000
`define RCM_DLY_CAL_NS     30000
`define RCM_DLY_SLOPE_NS   32000
`define RCM_CONV_SAMPLES   16
`endif

// ---- tb_top.sv ----
`include "rcm_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MEAS  = 2;
  localparam int CALU  = 3;
  localparam int SLOPE = 4;
  localparam int CONV  = 4;
  logic        CLK               = 1'b0;
  logic        RESETN            = 1'b0;
  logic [4:0]  ADDR              = 5'h00;
  logic [15:0] WDATA             = 16'h0000;
  logic        WR                = 1'b0;
  logic        RD                = 1'b0;
  logic [15:0] RDATA;
  logic        CHIP_DISABLE      = 1'b0;
  logic        MODE_SELECT_PIN_B = 1'b1;
  logic        TRX_STATE_ENABLE;
  logic        RX_PACKET_DONE    = 1'b0;
  logic        RX_SYNC           = 1'b0;
  logic        PKT_IND           = 1'b1;
  logic        RDY_IND           = 1'b0;
  logic        PKT_RDY_PIN;
  logic [7:0]  TEMP_SAMPLE       = 8'hA5;
  logic [7:0]  STRENGTH_SAMPLE   = 8'h30;
  logic [6:0]  IF_CAL_RESULT     = 7'h2B;
  logic        ADC_CLK_EN;
  logic        SAMPLE_STROBE;
  logic [6:0]  CAL_SELECT;
  logic [6:0]  IF_FILTER_VALUE;
  int          err_total = 0;
  int          tests_run = 0;
  logic [6:0]  cur       = 7'h00;
  int          dly       = 0;
  int          nstr      = 0;
  int          cyc       = 0;
  int          last_adc  = 0;
  int          adc_gap   = 0;
  int          q_sel[$];
  int          q_dly[$];
  int          q_str[$];
  int          d0;
  logic [15:0] d;

  rcm_ctrl #(.MEAS_UNIT_CYC(MEAS), .CAL_UNIT_CYC(CALU), .SLOPE_UNIT_CYC(SLOPE),
             .CONV_SAMPLES(CONV)) u_dut (
    .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CHIP_DISABLE(CHIP_DISABLE), .MODE_SELECT_PIN_B(MODE_SELECT_PIN_B),
    .TRX_STATE_ENABLE(TRX_STATE_ENABLE), .RX_PACKET_DONE(RX_PACKET_DONE),
    .RX_SYNC(RX_SYNC), .PKT_IND(PKT_IND), .RDY_IND(RDY_IND), .PKT_RDY_PIN(PKT_RDY_PIN),
    .TEMP_SAMPLE(TEMP_SAMPLE), .STRENGTH_SAMPLE(STRENGTH_SAMPLE),
    .IF_CAL_RESULT(IF_CAL_RESULT), .ADC_CLK_EN(ADC_CLK_EN), .SAMPLE_STROBE(SAMPLE_STROBE),
    .CAL_SELECT(CAL_SELECT), .IF_FILTER_VALUE(IF_FILTER_VALUE)
  );

  always #25 CLK = ~CLK;

  // job monitor: per job, cycles before first sample and sample count; overall, latest adc tick spacing
  always @(posedge CLK)
  begin
    if (CAL_SELECT !== cur)
    begin
      if (cur != 7'h00)
      begin
        q_sel.push_back(int'(cur));
        q_dly.push_back(dly);
        q_str.push_back(nstr);
      end
      cur = CAL_SELECT;
      dly = 0;
      nstr = 0;
    end
    if (CAL_SELECT != 7'h00)
    begin
      if (SAMPLE_STROBE === 1'b1)
        nstr++;
      else if (nstr == 0)
        dly++;
    end
    if (ADC_CLK_EN === 1'b1)
    begin
      adc_gap = cyc - last_adc;
      last_adc = cyc;
    end
    cyc++;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    @(negedge CLK);
    v = RDATA;
  endtask

  task automatic rdchk(input string n, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask

  // polls a register until the masked bits read zero
  task automatic wait_clear(input logic [4:0] a, input logic [15:0] m);
    logic [15:0] v;
    v = m;
    for (int n = 0; n < 300 && (v & m) !== 16'h0000; n++)
      rd(a, v);
    if ((v & m) !== 16'h0000)
    begin
      err_total++;
      $display("ERROR wait expected clear seen %h", v);
      final_report;
    end
  endtask

  initial
  begin
    #2_000_000;
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    final_report;
  end

  initial
  begin
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    rdchk("cal_a reset", 5'h0C, 16'hFE00);
    rdchk("cal_b reset", 5'h0D, 16'h0001);
    chk("trx en", {15'h0, TRX_STATE_ENABLE}, 16'h0001);
    @(posedge CLK);
    MODE_SELECT_PIN_B <= 1'b0;
    @(negedge CLK);
    chk("trx masked", {15'h0, TRX_STATE_ENABLE}, 16'h0000);
    rdchk("cal_b masked", 5'h0D, 16'h0000);
    @(posedge CLK);
    MODE_SELECT_PIN_B <= 1'b1;
    wr(5'h0D, 16'hFF80);
    rdchk("cal_b unused", 5'h0D, 16'h0000);
    wr(5'h1F, 16'hFFFF);
    rdchk("unmapped", 5'h1F, 16'h0000);
    wr(5'h0D, 16'h0001);
    $display("test registers done");
    for (int f = 0; f <= 2; f += 2)
    begin
      wr(5'h0E, 16'(f << 4));
      wr(5'h0C, 16'h0001);
      if (f == 2)
        rdchk("temp busy", 5'h0C, 16'h7E01);
      wait_clear(5'h0C, 16'h0001);
      // let the job monitor log the finished job before its queues are read
      repeat (2) @(posedge CLK);
      if (f == 0)
        d0 = q_dly[$];
      chk("temp samples", 16'(q_str[$]), 16'(CONV));
      rdchk("temp code", 5'h0A, 16'hA500);
      rdchk("temp ready", 5'h0C, 16'hFE00);
    end
    chk("meas delay", 16'(q_dly[$] - d0), 16'(MEAS * 3));
    $display("test temperature done");
    for (int m = 0; m < 3; m++)
    begin
      @(posedge CLK);
      STRENGTH_SAMPLE <= 8'h30 + 8'(m);
      wr(5'h0C, {13'h0, (m == 2) ? 2'b10 : 2'(m), 1'b0});
      wr(5'h0D, 16'h0005);
      if (m < 2)
      begin
        repeat (10) @(posedge CLK);
        chk("no trigger", {9'h0, CAL_SELECT}, 16'h0000);
        rdchk("str busy", 5'h0C, 16'hBE00 | 16'(m << 1));
        @(posedge CLK);
        if (m == 0)
          RX_PACKET_DONE <= 1'b1;
        else
          RX_SYNC <= 1'b1;
        @(posedge CLK);
        RX_PACKET_DONE <= 1'b0;
        RX_SYNC        <= 1'b0;
      end
      wait_clear(5'h0D, 16'h0004);
      rdchk("str code", 5'h0B, {8'h30 + 8'(m), 8'h00});
      rd(5'h0C, d);
      chk("str ready", d & 16'h4000, 16'h4000);
    end
    $display("test strength done");
    wr(5'h0E, 16'h0001);
    rdchk("adc setup write only", 5'h0E, 16'h0000);
    wr(5'h0C, 16'h0010);
    repeat (20) @(posedge CLK);
    chk("cal gated", {9'h0, CAL_SELECT}, 16'h0000);
    rdchk("cal gated flags", 5'h0C, 16'hFE10);
    q_sel.delete();
    q_dly.delete();
    q_str.delete();
    wr(5'h0C, 16'h01F0);
    wr(5'h0D, 16'h0003);
    rd(5'h0C, d);
    chk("cal flags low", d & 16'h3E00, 16'h0000);
    wait_clear(5'h0D, 16'h0002);
    chk("cal jobs", 16'(q_sel.size()), 16'h0005);
    for (int j = 0; j < 5 && j < q_sel.size(); j++)
      chk("cal order", 16'(q_sel[j]), 16'(1 << j));
    if (q_sel.size() == 5)
    begin
      chk("cal delay df", 16'(q_dly[1] - q_dly[0]), 16'h0000);
      chk("slope delay", 16'(q_dly[3] - q_dly[0]), 16'(SLOPE - CALU));
      chk("slope low", 16'(q_dly[4] - q_dly[3]), 16'h0000);
      chk("cal samples", 16'(q_str[0]), 16'(CONV));
    end
    chk("adc spacing", 16'(adc_gap), 16'h0004);
    rdchk("cal done flags", 5'h0C, 16'hFFF0);
    chk("if auto", {9'h0, IF_FILTER_VALUE}, 16'h002B);
    rdchk("if read", 5'h0F, 16'h5600);
    wr(5'h0C, 16'h0008);
    wr(5'h0F, 16'h00AA);
    @(negedge CLK);
    chk("if manual", {9'h0, IF_FILTER_VALUE}, 16'h0055);
    rdchk("if manual read", 5'h0F, 16'hAA00);
    $display("test calibration done");
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h0D, {11'h0, k[1], k[0], 3'b001});
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      chk("pin", {15'h0, PKT_RDY_PIN}, {15'h0, (k[0] ? 1'b0 : 1'b1) ^ k[1]});
    end
    $display("test pin done");
    // start a temperature job so that the disable lands mid-sequence
    wr(5'h0C, 16'h0001);
    wr(5'h0D, 16'h000C);
    @(posedge CLK);
    CHIP_DISABLE <= 1'b1;
    repeat (2) @(posedge CLK);
    CHIP_DISABLE <= 1'b0;
    rdchk("disable cal_b", 5'h0D, 16'h0009);
    rdchk("disable cal_a", 5'h0C, 16'hFE00);
    chk("disable idle", {9'h0, CAL_SELECT}, 16'h0000);
    $display("test disable done");
    final_report;
  end
endmodule
